// >>> rtl/apc_pkg.sv
// apc_pkg: constants and carrier types of the alarm-driven pwm cutoff block.
// assumes a single 40 mhz core clock and a 32-bit avalon-mm register bus.
`default_nettype none

package apc_pkg;

  // clocking
  localparam int CLK_HZ = 40_000_000;
  localparam int PWM_PERIOD_US = 100;
  localparam int PWM_DUTY_PCT = 50;
  localparam logic [15:0] PWM_PERIOD_CYC = 16'(PWM_PERIOD_US * (CLK_HZ / 1_000_000));
  localparam logic [15:0] PWM_ACTIVE_CYC = 16'((PWM_PERIOD_US * (CLK_HZ / 1_000_000))
                                               * PWM_DUTY_PCT / 100);
  localparam int SUB_CLK_HZ = 32768;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIME = 8'h04;
  localparam logic [7:0] REG_DATE = 8'h08;
  localparam logic [7:0] REG_ALARM = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_CUTOFF = 8'h18;

  // control bits
  localparam int CTRL_RTC_RUN = 0;
  localparam int CTRL_PWM_RUN = 1;
  localparam int CTRL_ALARM_EN = 2;
  localparam int CTRL_CUT_EN = 3;
  localparam int CTRL_ROUTE_EN = 4;
  localparam int CTRL_FIX_LSB = 5;
  localparam logic [7:0] CTRL_RST = 8'h18;

  // fixed-cycle selections
  localparam logic [2:0] FIX_OFF = 3'h0;
  localparam logic [2:0] FIX_SEC = 3'h1;
  localparam logic [2:0] FIX_MIN = 3'h2;
  localparam logic [2:0] FIX_HOUR = 3'h3;
  localparam logic [2:0] FIX_DAY = 3'h4;

  // status / mask bits
  localparam int ST_ALARM = 0;
  localparam int ST_CUTOFF = 1;
  localparam int ST_PERIOD = 2;
  localparam int ST_FIXED = 3;
  localparam logic [3:0] MASK_RST = 4'h1;

  // bcd limits
  localparam logic [7:0] BCD_SEC_MAX = 8'h59;
  localparam logic [7:0] BCD_HOUR_MAX = 8'h23;
  localparam logic [2:0] WDAY_MAX = 3'h6;

  typedef struct packed {
    logic [2:0] wday;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
  } apc_time_t;

  typedef struct packed {
    logic [7:0] year;
    logic [4:0] month;
    logic [5:0] day;
  } apc_date_t;

  typedef struct packed {
    logic [6:0] wdays;
    logic [5:0] hour;
    logic [6:0] min;
  } apc_alarm_t;

  // tuesday (0 = sunday), 0:00:00
  localparam apc_time_t TIME_RST = '{wday: 3'h2, hour: 6'h00, min: 7'h00, sec: 7'h00};
  // first day of the first month, year 2013 held as bcd 13
  localparam apc_date_t DATE_RST = '{year: 8'h13, month: 5'h01, day: 6'h01};
  // 2:00 on every weekday
  localparam apc_alarm_t ALARM_RST = '{wdays: 7'h7f, hour: 6'h02, min: 7'h00};

endpackage

`default_nettype wire

// >>> rtl/apc_top.sv
// apc_top: calendar with alarm, event route and pwm timer with forced cutoff.
// assumes an avalon-mm master on core_clk_in and a free 32.768 khz sub clock.
`default_nettype none

module apc_top #(
  parameter int SUB_TICKS_PER_SEC = apc_pkg::SUB_CLK_HZ
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // sub clock, sampled as data
  input wire logic sub_clk_in,
  // avalon-mm slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // pin and interrupt
  output logic pwm_output_pin_out,
  output logic irq_out
);

  logic [7:0] ctrl_q;
  apc_pkg::apc_time_t time_q;
  apc_pkg::apc_time_t time_d;
  apc_pkg::apc_date_t date_q;
  apc_pkg::apc_alarm_t alarm_q;
  logic [3:0] status_q;
  logic [3:0] mask_q;
  logic [3:0] status_set;
  logic [3:0] status_clr;
  logic cutoff_q;
  logic [15:0] pwm_cnt_q;
  logic pwm_q;
  logic pwm_running;
  logic [2:0] sub_sync_q;
  logic sub_rise;
  logic [15:0] presc_q;
  logic sec_tick_q;
  logic tick_done_q;
  logic alarm_evt_q;
  logic route_q;
  logic fixed_evt;
  logic wait_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic [2:0] fix_sel;

  // byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    be_merge = r;
  endfunction

  // one bcd step with wrap to zero past the top value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top);
    if (v == top) begin
      bcd_inc = 8'h00;
    end else if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = v + 8'h01;
    end
  endfunction

  // a bus write completes at the edge that sees waitrequest low
  function automatic logic wr_sel(input logic [7:0] off);
    wr_sel = avs_write_in && !wait_q && (avs_address_in[7:2] == off[7:2]);
  endfunction

  function automatic logic [31:0] time_word(input apc_pkg::apc_time_t t);
    time_word = {5'h00, t.wday, 2'h0, t.hour, 1'b0, t.min, 1'b0, t.sec};
  endfunction

  function automatic apc_pkg::apc_time_t word_time(input logic [31:0] w);
    word_time = '{wday: w[26:24], hour: w[21:16], min: w[14:8], sec: w[6:0]};
  endfunction

  function automatic logic [31:0] date_word(input apc_pkg::apc_date_t d);
    date_word = {8'h00, d.year, 3'h0, d.month, 2'h0, d.day};
  endfunction

  function automatic logic [31:0] alarm_word(input apc_pkg::apc_alarm_t a);
    alarm_word = {9'h000, a.wdays, 2'h0, a.hour, 1'b0, a.min};
  endfunction

  // reserved bits of a bus word are dropped on the way into the fields
  function automatic apc_pkg::apc_date_t word_date(input logic [31:0] w);
    word_date = '{year: w[23:16], month: w[12:8], day: w[5:0]};
  endfunction

  function automatic apc_pkg::apc_alarm_t word_alarm(input logic [31:0] w);
    word_alarm = '{wdays: w[22:16], hour: w[13:8], min: w[6:0]};
  endfunction

  assign fix_sel = ctrl_q[apc_pkg::CTRL_FIX_LSB +: 3];
  assign sub_rise = sub_sync_q[1] && !sub_sync_q[2];
  assign pwm_running = ctrl_q[apc_pkg::CTRL_PWM_RUN] && !cutoff_q;

  // sub clock sampled as a level; only stages two and three feed the edge
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sub_sync_q <= 3'h0;
    end else begin
      sub_sync_q <= {sub_sync_q[1:0], sub_clk_in};
    end
  end

  // one-second prescaler on sub clock edges
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      presc_q <= 16'h0000;
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= 1'b0;
      if (!ctrl_q[apc_pkg::CTRL_RTC_RUN]) begin
        presc_q <= 16'h0000;
      end else if (sub_rise) begin
        if (presc_q == 16'(SUB_TICKS_PER_SEC - 1)) begin
          presc_q <= 16'h0000;
          sec_tick_q <= 1'b1;
        end else begin
          presc_q <= presc_q + 16'h0001;
        end
      end
    end
  end

  // next calendar time, 24-hour only
  always_comb begin
    time_d = time_q;
    time_d.sec = 7'(bcd_inc({1'b0, time_q.sec}, apc_pkg::BCD_SEC_MAX));
    if (time_q.sec == 7'(apc_pkg::BCD_SEC_MAX)) begin
      time_d.min = 7'(bcd_inc({1'b0, time_q.min}, apc_pkg::BCD_SEC_MAX));
      if (time_q.min == 7'(apc_pkg::BCD_SEC_MAX)) begin
        time_d.hour = 6'(bcd_inc({2'h0, time_q.hour}, apc_pkg::BCD_HOUR_MAX));
        if (time_q.hour == 6'(apc_pkg::BCD_HOUR_MAX)) begin
          time_d.wday = (time_q.wday == apc_pkg::WDAY_MAX) ? 3'h0 : time_q.wday + 3'h1;
        end
      end
    end
  end

  // calendar counters; a bus load wins over a tick in the same cycle
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      time_q <= apc_pkg::TIME_RST;
      date_q <= apc_pkg::DATE_RST;
      tick_done_q <= 1'b0;
    end else begin
      tick_done_q <= sec_tick_q;
      if (wr_sel(apc_pkg::REG_TIME)) begin
        time_q <= word_time(be_merge(time_word(time_q), avs_writedata_in, avs_byteenable_in));
      end else if (sec_tick_q) begin
        time_q <= time_d;
      end
      if (wr_sel(apc_pkg::REG_DATE)) begin
        date_q <= word_date(be_merge(date_word(date_q), avs_writedata_in, avs_byteenable_in));
      end
    end
  end

  // alarm and fixed-cycle events, judged once the new second has settled
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      alarm_evt_q <= 1'b0;
      route_q <= 1'b0;
    end else begin
      // only the first second of the minute fires, so one event per match
      alarm_evt_q <= tick_done_q && ctrl_q[apc_pkg::CTRL_ALARM_EN] &&
                     ctrl_q[apc_pkg::CTRL_RTC_RUN] && (time_q.sec == 7'h00) &&
                     (time_q.min == alarm_q.min) && (time_q.hour == alarm_q.hour) &&
                     alarm_q.wdays[time_q.wday];
      route_q <= alarm_evt_q && ctrl_q[apc_pkg::CTRL_ROUTE_EN];
    end
  end

  always_comb begin
    case (fix_sel)
      apc_pkg::FIX_OFF: fixed_evt = 1'b0;
      apc_pkg::FIX_SEC: fixed_evt = tick_done_q;
      apc_pkg::FIX_MIN: fixed_evt = tick_done_q && time_q.sec == 7'h00;
      apc_pkg::FIX_HOUR: fixed_evt = tick_done_q && time_q.sec == 7'h00 && time_q.min == 7'h00;
      apc_pkg::FIX_DAY: fixed_evt = tick_done_q && time_q.sec == 7'h00 &&
                                    time_q.min == 7'h00 && time_q.hour == 6'h00;
      default: fixed_evt = 1'b0;
    endcase
  end

  // forced cutoff latch; a new request wins over a software clear
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cutoff_q <= 1'b0;
    end else if (route_q && ctrl_q[apc_pkg::CTRL_CUT_EN]) begin
      cutoff_q <= 1'b1;
    end else if (wr_sel(apc_pkg::REG_CUTOFF) && avs_byteenable_in[0] && avs_writedata_in[0]) begin
      cutoff_q <= 1'b0;
    end
  end

  // pwm: first half of each period inactive, second half high
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pwm_cnt_q <= 16'h0000;
      pwm_q <= 1'b0;
    end else if (!pwm_running) begin
      // restart after a clear begins again at the inactive level
      pwm_cnt_q <= 16'h0000;
      pwm_q <= 1'b0;
    end else begin
      if (pwm_cnt_q == apc_pkg::PWM_PERIOD_CYC - 16'h0001) begin
        pwm_cnt_q <= 16'h0000;
      end else begin
        pwm_cnt_q <= pwm_cnt_q + 16'h0001;
      end
      pwm_q <= (pwm_cnt_q >= apc_pkg::PWM_ACTIVE_CYC);
    end
  end

  // sticky status, write one to clear, set wins
  always_comb begin
    status_set = 4'h0;
    status_set[apc_pkg::ST_ALARM] = alarm_evt_q;
    status_set[apc_pkg::ST_CUTOFF] = route_q && ctrl_q[apc_pkg::CTRL_CUT_EN];
    status_set[apc_pkg::ST_PERIOD] = pwm_running &&
                                     (pwm_cnt_q == apc_pkg::PWM_PERIOD_CYC - 16'h0001);
    status_set[apc_pkg::ST_FIXED] = fixed_evt;
    status_clr = 4'h0;
    if (wr_sel(apc_pkg::REG_STATUS) && avs_byteenable_in[0]) begin
      status_clr = avs_writedata_in[3:0];
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      status_q <= (status_q & ~status_clr) | status_set;
      irq_q <= |(status_q & mask_q);
    end
  end

  // software-written configuration
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_q <= apc_pkg::CTRL_RST;
      mask_q <= apc_pkg::MASK_RST;
      alarm_q <= apc_pkg::ALARM_RST;
    end else begin
      if (wr_sel(apc_pkg::REG_CTRL) && avs_byteenable_in[0]) begin
        ctrl_q <= avs_writedata_in[7:0];
      end
      if (wr_sel(apc_pkg::REG_MASK) && avs_byteenable_in[0]) begin
        mask_q <= avs_writedata_in[3:0];
      end
      if (wr_sel(apc_pkg::REG_ALARM)) begin
        alarm_q <= word_alarm(be_merge(alarm_word(alarm_q), avs_writedata_in,
                                       avs_byteenable_in));
      end
    end
  end

  // bus slave: every access waits exactly one cycle, then completes
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      if ((avs_read_in || avs_write_in) && wait_q) begin
        wait_q <= 1'b0;
      end else begin
        wait_q <= 1'b1;
      end
      if (avs_read_in && wait_q) begin
        case ({avs_address_in[7:2], 2'b00})
          apc_pkg::REG_CTRL: rdata_q <= {24'h000000, ctrl_q};
          apc_pkg::REG_TIME: rdata_q <= time_word(time_q);
          apc_pkg::REG_DATE: rdata_q <= date_word(date_q);
          apc_pkg::REG_ALARM: rdata_q <= alarm_word(alarm_q);
          apc_pkg::REG_STATUS: rdata_q <= {28'h0000000, status_q};
          apc_pkg::REG_MASK: rdata_q <= {28'h0000000, mask_q};
          apc_pkg::REG_CUTOFF: rdata_q <= {29'h00000000, pwm_q, pwm_running, cutoff_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign pwm_output_pin_out = pwm_q;
  assign irq_out = irq_q;

endmodule

`default_nettype wire

// >>> verif/apc_load.sv
// apc_load: load on the pwm pin, measures the last high and low runs.
// assumes the pin is sampled on the core clock.
`default_nettype none
module apc_load (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic [15:0] hi_len_out,
  output logic [15:0] lo_len_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] run_q;
  logic pin_q;
  // active level is high, so high runs count as on time
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_q <= '0;
      pin_q <= 1'b0;
      hi_len_out <= '0;
      lo_len_out <= '0;
    end else begin
      pin_q <= pin_in;
      run_q <= (pin_in != pin_q) ? 16'h1 : run_q + 16'h1;
      if (pin_in && !pin_q)
        lo_len_out <= run_q;
      if (!pin_in && pin_q)
        hi_len_out <= run_q;
    end
  end
endmodule
`default_nettype wire

// >>> verif/apc_monitor.sv
// apc_monitor: port-level assertions for apc_top.
// assumes it is bound into apc_top and shares its clock and reset.
`default_nettype none
module apc_monitor #(
  parameter int SUB_TICKS_PER_SEC = 32768
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // register bus
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // pin and interrupt
  input wire logic pwm_output_pin_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [15:0] hi_q;
  logic [15:0] per_q;
  logic pin_q;
  logic seen_q;
  logic cut_q;
  wire logic pin = pwm_output_pin_out;
  wire logic wt = avs_waitrequest_out;
  wire logic cut_adr = avs_address_in == 8'h18;
  wire logic rd_ok = avs_read_in && !wt;
  wire logic wr_ok = avs_write_in && !wt;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hi_q <= '0;
      per_q <= '0;
      pin_q <= 1'b0;
    end else begin
      hi_q <= pin ? hi_q + 16'h1 : '0;
      per_q <= (pin && !pin_q) ? 16'h1 : per_q + 16'h1;
      pin_q <= pin;
    end
  end
  // a software restart voids the next period measurement
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      seen_q <= 1'b0;
      cut_q <= 1'b0;
    end else begin
      if (wr_ok && (cut_adr || avs_address_in == 8'h00))
        seen_q <= 1'b0;
      else if (pin && !pin_q)
        seen_q <= 1'b1;
      if (wr_ok && cut_adr)
        cut_q <= 1'b0;
      else if (rd_ok && cut_adr && avs_readdata_out[0])
        cut_q <= 1'b1;
    end
  end
  property p_hi_max; pin |-> hi_q < 16'h7d0; endproperty
  a_hi_max: assert property (p_hi_max) else $error("pwm high run too long");
  property p_period; $rose(pin) && seen_q |-> per_q == 16'hfa0; endproperty
  a_period: assert property (p_period) else $error("pwm period wrong");
  property p_rst_low; $fell(sys_rst_in) |-> !pin ##1 !pin; endproperty
  a_rst_low: assert property (p_rst_low) else $error("pin not idle low");
  property p_cut_rd; rd_ok && cut_adr && avs_readdata_out[0] |-> !pin; endproperty
  a_cut_rd: assert property (p_cut_rd) else $error("pin driven in cutoff");
  property p_cut_hold; cut_q |-> !pin; endproperty
  a_cut_hold: assert property (p_cut_hold) else $error("cutoff released early");
  property p_ack; (avs_read_in || avs_write_in) && wt |=> !wt; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_ack_one; $fell(wt) |=> wt; endproperty
  a_ack_one: assert property (p_ack_one) else $error("bus answer too long");
  property p_quiet; $fell(sys_rst_in) |-> wt && !irq_out; endproperty
  a_quiet: assert property (p_quiet) else $error("not quiet after reset");
  c_fall: cover property ($fell(pin));
  c_cut: cover property (cut_q);
  c_irq: cover property ($rose(irq_out));
endmodule
bind apc_top apc_monitor #(.SUB_TICKS_PER_SEC(SUB_TICKS_PER_SEC)) u_mon (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .pwm_output_pin_out(pwm_output_pin_out), .irq_out(irq_out));
`default_nettype wire

// >>> verif/apc_top_tb.sv
// apc_top_tb: directed scenarios for the alarm-driven pwm cutoff block.
// assumes apc_top, apc_load and the bound apc_monitor are compiled.
`default_nettype none
module apc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sub = 1'b0;
  logic [7:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wt;
  logic pin;
  logic irq;
  logic [15:0] hi_len;
  logic [15:0] lo_len;
  int num_errors = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  always #100 sub = ~sub;
  apc_top #(.SUB_TICKS_PER_SEC(4)) i_dut (
    .core_clk_in(clk), .sys_rst_in(rst), .sub_clk_in(sub), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
    .pwm_output_pin_out(pin), .irq_out(irq));
  apc_load i_load (.clk_in(clk), .rst_in(rst), .pin_in(pin),
    .hi_len_out(hi_len), .lo_len_out(lo_len));
  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 100);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    chk({31'h0, wt}, 32'h0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  // lim of 0 turns this into a plain check of the level now
  task automatic wait_sig(input bit use_irq, input logic v, input int lim);
    int n;
    n = 0;
    while ((use_irq ? irq : pin) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, use_irq ? irq : pin}, {31'h0, v});
  endtask
  task automatic t_reset();
    wait_sig(0, 1'b0, 0);
    rd_chk(8'h00, 32'hff, 32'h18);
    rd_chk(8'h04, '1, 32'h0200_0000);
    rd_chk(8'h08, '1, 32'h0013_0101);
    rd_chk(8'h0c, '1, 32'h007f_0200);
    rd_chk(8'h14, 32'hf, 32'h1);
    rd_chk(8'h10, 32'hf, 32'h0);
    bus(1'b1, 8'h1c, '1);
    rd_chk(8'h1c, '1, 32'h0);
  endtask
  task automatic t_pwm();
    bus(1'b1, 8'h00, 32'h1a);
    wait_sig(0, 1'b1, 2200);
    wait_sig(0, 1'b0, 2100);
    wait_sig(0, 1'b1, 2100);
    repeat (2) @(posedge clk);
    chk({16'h0, hi_len}, 32'h7d0);
    chk({16'h0, lo_len}, 32'h7d0);
  endtask
  // tuesday left out of the weekdays, then the alarm function off with a per-second tick
  task automatic t_noalarm();
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 8'h0c, i ? 32'h007f_0200 : 32'h007b_0200);
      bus(1'b1, 8'h04, 32'h0201_5958);
      bus(1'b1, 8'h00, i ? 32'h3b : 32'h1f);
      repeat (300) @(posedge clk);
      wait_sig(1, 1'b0, 0);
      rd_chk(8'h04, 32'h07ff_ff00, 32'h0202_0000);
      rd_chk(8'h10, 32'h3, 32'h0);
      rd_chk(8'h10, 32'h8, i ? 32'h8 : 32'h0);
    end
  endtask
  task automatic t_alarm();
    bus(1'b1, 8'h04, 32'h0201_5958);
    bus(1'b1, 8'h00, 32'h1f);
    wait_sig(1, 1'b1, 1000);
    repeat (4) @(posedge clk);
    wait_sig(0, 1'b0, 0);
    rd_chk(8'h10, 32'h3, 32'h3);
    rd_chk(8'h18, 32'h1, 32'h1);
    repeat (6000) @(posedge clk);
    wait_sig(0, 1'b0, 0);
    bus(1'b1, 8'h10, 32'hf);
    wait_sig(1, 1'b0, 3);
    bus(1'b1, 8'h18, 32'h1);
    wait_sig(0, 1'b1, 2200);
    repeat (4100) @(posedge clk);
    wait_sig(1, 1'b0, 0);
    rd_chk(8'h10, 32'h4, 32'h4);
    bus(1'b1, 8'h14, 32'h4);
    wait_sig(1, 1'b1, 3);
    bus(1'b1, 8'h14, 32'h1);
    bus(1'b1, 8'h10, 32'hf);
    wait_sig(1, 1'b0, 3);
  endtask
  initial begin
    #1_000_000;
    chk(32'h0, 32'h1);
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pwm();
    t_noalarm();
    t_alarm();
    conclude();
  end
endmodule
`default_nettype wire
